// File: verilog/sram_port_pkg.sv
// Shared constants for the two-beat double-data-rate SRAM port.
`default_nettype none

package sram_port_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ADDR_WIDTH_X18 = 23;
  localparam int DATA_WIDTH_X18 = 18;
  localparam int ADDR_WIDTH_X36 = 22;
  localparam int DATA_WIDTH_X36 = 36;
  localparam int LANE_BITS      = 9;
  localparam int BURST_LEN      = 2;

  // ****************************************************************
  // Link clock pin positions in the synchronised clock vector
  // ****************************************************************
  localparam int CLK_IN_P  = 0;
  localparam int CLK_IN_N  = 1;
  localparam int CLK_OUT_P = 2;
  localparam int CLK_OUT_N = 3;
  localparam int CLK_COUNT = 4;

  // ****************************************************************
  // Read pipeline, counted in output clock rising edges
  // ****************************************************************
  localparam logic [2:0] LAT_EDGES_PLL  = 3'h4;
  localparam logic [2:0] LAT_EDGES_DDR1 = 3'h3;
  localparam logic [2:0] BEAT0_CNT      = 3'h2;
  localparam logic [2:0] BEAT1_CNT      = 3'h1;
  localparam int         RD_SLOTS       = 3;

  // ****************************************************************
  // Single clock mode detection
  // ****************************************************************
  localparam logic [5:0] STATIC_CYCLES = 6'h18;

endpackage : sram_port_pkg

`default_nettype wire

// File: verilog/pin_sync.sv
// Two-stage synchroniser with rising edge detection for link pins.
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  // Pins from outside the clock domain
  input  wire logic [WIDTH-1:0] pin_async,
  // Synchronised view
  output logic      [WIDTH-1:0] pin_level,
  output logic      [WIDTH-1:0] pin_rise
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end else if (clk_en) begin
      stage1_q <= pin_async;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  assign pin_level = stage2_q;
  assign pin_rise  = stage2_q & ~stage3_q;

endmodule : pin_sync

`default_nettype wire

// File: verilog/ddr_burst2_sram_port.sv
// Two-beat double-data-rate common-I/O SRAM port with memory array.
//
// Behaviour
// - Write data sampled on both input clock rises.
// - Read beats driven on both output clock rises.
// - Data outputs float whenever no read beat.
// - Every access is exactly two beats.
// - Byte lane selects sampled per write beat.
// - Unselected byte lanes stay unchanged.
// - One address bus serves reads and writes.
// - Linear burst counter seeded from burst start bit.
// - Address width 23 for x18, 22 for x36.
// - Address ignored while port is deselected.
// - Output clock pair times read data.
// - Inputs captured, accesses begin on positive clock.
// - Negative input clock captures data, single-mode launch.
// - Free-running complementary echo clocks follow output timing.
// - Latency 1.5 cycles, one cycle with PLL off.
// - Control inputs registered on positive clock only.
`default_nettype none

module ddr_burst2_sram_port #(
  parameter int ADDR_WIDTH = sram_port_pkg::ADDR_WIDTH_X18,
  parameter int DATA_WIDTH = sram_port_pkg::DATA_WIDTH_X18
) (
  // System clock, reset and enable
  input  wire logic                                     clk_sys,
  input  wire logic                                     reset_n,
  input  wire logic                                     clk_en,
  // Link clocks
  input  wire logic                                     in_clk_p,
  input  wire logic                                     in_clk_n,
  input  wire logic                                     out_clk_p,
  input  wire logic                                     out_clk_n,
  // Command pins
  input  wire logic                                     load_strobe_n,
  input  wire logic                                     access_direction,
  input  wire logic [ADDR_WIDTH-1:1]                    address,
  input  wire logic                                     burst_start_bit,
  input  wire logic [DATA_WIDTH/sram_port_pkg::LANE_BITS-1:0] byte_lane_write_select_n,
  input  wire logic                                     pll_disable_n,
  // Data pins
  input  wire logic [DATA_WIDTH-1:0]                    dq_in,
  output logic      [DATA_WIDTH-1:0]                    dq_out,
  output logic                                          dq_oe,
  // Echo clocks
  output logic                                          echo_clock_p,
  output logic                                          echo_clock_n
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  localparam int LANES = DATA_WIDTH / sram_port_pkg::LANE_BITS;
  localparam int PIN_W = 3 + ADDR_WIDTH + LANES + DATA_WIDTH;
  localparam int NSLOT = sram_port_pkg::RD_SLOTS;
  localparam int LB    = sram_port_pkg::LANE_BITS;

  logic [sram_port_pkg::CLK_COUNT-1:0] clk_lvl;
  logic [sram_port_pkg::CLK_COUNT-1:0] clk_rise;
  logic [PIN_W-1:0]                    pin_lvl;
  logic                                pll_s;
  logic                                dir_s;
  logic                                load_n_s;
  logic [LANES-1:0]                    lane_n_s;
  logic [ADDR_WIDTH-1:0]               addr_s;
  logic [DATA_WIDTH-1:0]               din_s;

  // Clocks and pins share one stage count, so data stays aligned to edges.
  pin_sync #(
    .WIDTH (sram_port_pkg::CLK_COUNT)
  ) u_clk_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .pin_async ({out_clk_n, out_clk_p, in_clk_n, in_clk_p}),
    .pin_level (clk_lvl),
    .pin_rise  (clk_rise)
  );

  pin_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .pin_async ({pll_disable_n, access_direction, load_strobe_n, byte_lane_write_select_n,
                 address, burst_start_bit, dq_in}),
    .pin_level (pin_lvl),
    .pin_rise  ()
  );

  assign {pll_s, dir_s, load_n_s, lane_n_s, addr_s, din_s} = pin_lvl;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // linear burst counter
  function automatic logic [ADDR_WIDTH-1:0] beat_addr(input logic [ADDR_WIDTH-1:0] base,
                                                       input logic                  beat);
    beat_addr = {base[ADDR_WIDTH-1:1], base[0] ^ beat};
  endfunction : beat_addr

  // ****************************************************************
  // Clock mode and edge selection
  // ****************************************************************
  logic [5:0] static_cnt_q;
  logic       single_mode;
  logic       k_rise;
  logic       kn_rise;
  logic       out_p_rise;
  logic       out_n_rise;
  logic       out_edge;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      static_cnt_q <= 6'h00;
    end else if (clk_en) begin
      if (!(clk_lvl[sram_port_pkg::CLK_OUT_P] && clk_lvl[sram_port_pkg::CLK_OUT_N])) begin
        static_cnt_q <= 6'h00;
      end else if (static_cnt_q != sram_port_pkg::STATIC_CYCLES) begin
        static_cnt_q <= static_cnt_q + 6'h01;
      end
    end
  end
  assign single_mode = (static_cnt_q == sram_port_pkg::STATIC_CYCLES);
  assign k_rise      = clk_rise[sram_port_pkg::CLK_IN_P];
  assign kn_rise     = clk_rise[sram_port_pkg::CLK_IN_N];

  assign out_p_rise = single_mode ? k_rise : clk_rise[sram_port_pkg::CLK_OUT_P];
  assign out_n_rise = single_mode ? kn_rise : clk_rise[sram_port_pkg::CLK_OUT_N];
  assign out_edge   = out_p_rise | out_n_rise;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic rd_cmd;
  logic wr_cmd;

  assign rd_cmd = k_rise & ~load_n_s & dir_s;
  assign wr_cmd = k_rise & ~load_n_s & ~dir_s;

  // ****************************************************************
  // Write pipeline and array
  // ****************************************************************
  logic [DATA_WIDTH-1:0] array_mem [0:(1<<ADDR_WIDTH)-1];
  logic                  wr_a_v_q;
  logic [ADDR_WIDTH-1:0] wr_a_addr_q;
  logic                  wr_b_v_q;
  logic [ADDR_WIDTH-1:0] wr_b_addr_q;

  // Stage a waits for beat 0, stage b for beat 1, so writes can run back to back.
  // capture on positive clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_a_v_q    <= 1'b0;
      wr_a_addr_q <= '0;
      wr_b_v_q    <= 1'b0;
      wr_b_addr_q <= '0;
    end else if (clk_en) begin
      if (k_rise) begin
        wr_b_v_q    <= wr_a_v_q;
        wr_b_addr_q <= wr_a_addr_q;
        wr_a_v_q    <= wr_cmd;
        if (wr_cmd) begin
          wr_a_addr_q <= addr_s;
        end
      end else if (kn_rise) begin
        wr_b_v_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (k_rise && wr_a_v_q && !lane_n_s[i]) begin
          array_mem[beat_addr(wr_a_addr_q, 1'b0)][i*LB +: LB] <= din_s[i*LB +: LB];
        end
        if (kn_rise && wr_b_v_q && !lane_n_s[i]) begin
          array_mem[beat_addr(wr_b_addr_q, 1'b1)][i*LB +: LB] <= din_s[i*LB +: LB];
        end
      end
    end
  end

  // ****************************************************************
  // Read pipeline
  // ****************************************************************
  logic                  rd_v_q    [NSLOT];
  logic [ADDR_WIDTH-1:0] rd_addr_q [NSLOT];
  logic [2:0]            rd_cnt_q  [NSLOT];
  logic [NSLOT-1:0]      slot_free;
  logic [NSLOT-1:0]      alloc;
  logic                  launch;
  logic [DATA_WIDTH-1:0] rd_word;

  // Three slots cover back-to-back reads even when the output clocks lag the input pair.
  always_comb begin
    alloc = '0;
    for (int i = 0; i < NSLOT; i++) begin
      slot_free[i] = !rd_v_q[i] || (out_edge && rd_cnt_q[i] == sram_port_pkg::BEAT1_CNT);
    end
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (slot_free[i]) begin
        alloc = '0;
        alloc[i] = rd_cmd;
      end
    end
  end
  generate
    for (genvar g = 0; g < NSLOT; g++) begin : g_slot
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          rd_v_q[g]    <= 1'b0;
          rd_addr_q[g] <= '0;
          rd_cnt_q[g]  <= 3'h0;
        end else if (clk_en) begin
          if (alloc[g]) begin
            rd_v_q[g]    <= 1'b1;
            rd_addr_q[g] <= addr_s;
            rd_cnt_q[g]  <= pll_s ? sram_port_pkg::LAT_EDGES_PLL : sram_port_pkg::LAT_EDGES_DDR1;
          end else if (out_edge && rd_v_q[g]) begin
            rd_cnt_q[g] <= rd_cnt_q[g] - 3'h1;
            if (rd_cnt_q[g] == sram_port_pkg::BEAT1_CNT) begin
              rd_v_q[g] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  always_comb begin
    launch  = 1'b0;
    rd_word = '0;
    for (int i = 0; i < NSLOT; i++) begin
      if (out_edge && rd_v_q[i] && (rd_cnt_q[i] == sram_port_pkg::BEAT0_CNT ||
                                    rd_cnt_q[i] == sram_port_pkg::BEAT1_CNT)) begin
        launch  = 1'b1;
        rd_word = array_mem[beat_addr(rd_addr_q[i], rd_cnt_q[i] == sram_port_pkg::BEAT1_CNT)];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else if (clk_en) begin
      if (out_edge) begin
        dq_oe <= launch;
        if (launch) begin
          dq_out <= rd_word;
        end
      end
    end
  end

  // ****************************************************************
  // Echo clocks
  // ****************************************************************
  // free-running echo pair
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      echo_clock_p <= 1'b0;
      echo_clock_n <= 1'b1;
    end else if (clk_en) begin
      echo_clock_p <= single_mode ? clk_lvl[sram_port_pkg::CLK_IN_P]
                                  : clk_lvl[sram_port_pkg::CLK_OUT_P];
      echo_clock_n <= single_mode ? clk_lvl[sram_port_pkg::CLK_IN_N]
                                  : clk_lvl[sram_port_pkg::CLK_OUT_N];
    end
  end

endmodule : ddr_burst2_sram_port
`default_nettype wire

// File: verif/host_link_model.sv
// Host side clock source for the SRAM port bench.
`default_nettype none

module host_link_model (
  // Mode select
  input  wire logic single,
  // Link clocks
  output logic      in_clk_p,
  output logic      in_clk_n,
  output logic      out_clk_p,
  output logic      out_clk_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic k = 1'b0;
  // The offset keeps link edges clear of the system clock edges.
  initial begin
    #7;
    forever #80 k = ~k;
  end
  assign in_clk_p = k;
  assign in_clk_n = ~k;
  assign out_clk_p = single | k;
  assign out_clk_n = single | ~k;
endmodule : host_link_model

`default_nettype wire

// File: verif/sram_port_chk.sv
// Pin checker for the two-beat SRAM port.
`default_nettype none

module sram_port_chk #(
  parameter int DATA_WIDTH = 18
) (
  // Clocks and reset
  input wire logic                  clk_sys,
  input wire logic                  reset_n,
  input wire logic                  in_clk_p,
  input wire logic                  in_clk_n,
  input wire logic                  out_clk_p,
  input wire logic                  out_clk_n,
  // Pins
  input wire logic                  load_strobe_n,
  input wire logic                  access_direction,
  input wire logic [DATA_WIDTH-1:0] dq_out,
  input wire logic                  dq_oe,
  input wire logic                  echo_clock_p,
  input wire logic                  echo_clock_n
);
  logic [3:0] norm_q;
  logic [5:0] hi_q;
  logic [4:0] age_q;
  logic       steady;
  // Mode counters let echo checks skip the mode change itself.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      norm_q <= 4'h0;
      hi_q   <= 6'h0;
    end else begin
      norm_q <= (out_clk_p & out_clk_n) ? 4'h0 : (norm_q == 4'hF ? norm_q : norm_q + 4'h1);
      hi_q   <= !(out_clk_p & out_clk_n) ? 6'h0 : (hi_q == 6'h3F ? hi_q : hi_q + 6'h1);
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      age_q <= 5'h1F;
    end else begin
      age_q <= (!load_strobe_n && access_direction) ? 5'h0 :
               (age_q == 5'h1F ? age_q : age_q + 5'h1);
    end
  end
  assign steady = (norm_q == 4'hF) || (hi_q == 6'h3F);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  chk_echo_follow_out: assert property (
    norm_q == 4'hF |-> echo_clock_p == $past(out_clk_p, 3) && echo_clock_n == $past(out_clk_n, 3))
    else $error("echo clocks do not follow output clocks");
  chk_echo_single_mode: assert property (
    hi_q == 6'h3F |-> echo_clock_p == $past(in_clk_p, 3) && echo_clock_n == $past(in_clk_n, 3))
    else $error("echo clocks do not follow input clocks");
  chk_echo_free_run: assert property (
    steady |-> ##[1:5] $changed(echo_clock_p))
    else $error("echo clock stopped");
  chk_echo_complement: assert property (
    steady |-> echo_clock_p != echo_clock_n)
    else $error("echo clocks not complementary");
  chk_oe_needs_read: assert property (
    $rose(dq_oe) |-> age_q <= 5'h18)
    else $error("data driven without a read");
  chk_oe_idle_float: assert property (
    age_q == 5'h1F |-> !dq_oe)
    else $error("data driven long after last read");
  chk_burst_two_beats: assert property (
    $rose(dq_oe) |-> dq_oe [*7])
    else $error("read burst shorter than two beats");
  chk_beat_holds: assert property (
    dq_oe && $changed(dq_out) |=> $stable(dq_out) [*2])
    else $error("read beat changed between output clock edges");
endmodule : sram_port_chk

`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the two-beat SRAM port.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, reset_n = 1'b0, single = 1'b0, mon_en = 1'b0;
  logic        load_strobe_n = 1'b1, access_direction = 1'b0, burst_start_bit = 1'b0;
  logic        pll_disable_n = 1'b1, pend = 1'b0, prev_rd = 1'b0, all_lanes = 1'b0;
  logic [9:1]  address = 9'h0, last_rd = 9'h0;
  logic [1:0]  byte_lane_write_select_n = 2'h3, pl0, pl1;
  logic [17:0] dq_in = 18'h0, pd0, pd1;
  logic [17:0] mem [1024];
  logic [17:0] exp_d [int];
  int          seed = 39787, slot = 0, num_errors = 0, checked = 0;
  wire logic   in_clk_p, in_clk_n, out_clk_p, out_clk_n, dq_oe, echo_clock_p, echo_clock_n;
  wire logic [17:0] dq_out;
  wire logic   ep = single ? in_clk_p : out_clk_p;
  wire logic   en = single ? in_clk_n : out_clk_n;

  always #10 clk_sys = ~clk_sys;
  host_link_model i_host (.single, .in_clk_p, .in_clk_n, .out_clk_p, .out_clk_n);
  ddr_burst2_sram_port #(.ADDR_WIDTH(10), .DATA_WIDTH(18)) i_dut (
    .clk_sys, .reset_n, .clk_en(1'b1), .in_clk_p, .in_clk_n, .out_clk_p, .out_clk_n,
    .load_strobe_n, .access_direction, .address, .burst_start_bit,
    .byte_lane_write_select_n, .pll_disable_n, .dq_in, .dq_out, .dq_oe,
    .echo_clock_p, .echo_clock_n);

  task automatic check(string what, logic [17:0] seen, logic [17:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask : check

  function automatic logic [17:0] merge(logic [17:0] old, logic [17:0] nw, logic [1:0] sel_n);
    for (int i = 0; i < 2; i++)
      if (!sel_n[i]) old[i*9 +: 9] = nw[i*9 +: 9];
    return old;
  endfunction : merge

  // Sampling mid-beat keeps clear of the synchroniser jitter.
  task automatic sample(int s);
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    if (mon_en && exp_d.exists(s)) begin
      check("read enable", 18'(dq_oe), 18'h1);
      check("read data", dq_out, exp_d[s]);
      exp_d.delete(s);
    end else if (mon_en) begin
      check("idle enable", 18'(dq_oe), 18'h0);
    end
  endtask : sample
  always @(posedge ep) begin
    slot++;
    sample(slot);
  end
  always @(posedge en) begin
    slot++;
    sample(slot);
  end

  task automatic q_at(bit kn);
    if (kn) @(posedge in_clk_p);
    else @(posedge in_clk_n);
    repeat (2) @(posedge clk_sys);
  endtask : q_at

  task automatic op(bit sel, bit rd, logic [9:1] a, bit b0);
    int lat;
    lat = pll_disable_n ? 3 : 2;
    // A write right after a read of the same burst would race its launch.
    if (sel && !rd && prev_rd && a == last_rd) a = ~a;
    q_at(1'b0);
    load_strobe_n    <= ~sel;
    access_direction <= rd;
    address          <= a;
    burst_start_bit  <= b0;
    dq_in            <= pend ? pd0 : 18'($random(seed));
    byte_lane_write_select_n <= pend ? pl0 : 2'($random(seed));
    if (sel && rd) begin
      exp_d[slot + 1 + lat] = mem[{a, b0}];
      exp_d[slot + 2 + lat] = mem[{a, ~b0}];
    end
    prev_rd = sel && rd;
    last_rd = a;
    q_at(1'b1);
    dq_in <= pend ? pd1 : 18'($random(seed));
    byte_lane_write_select_n <= pend ? pl1 : 2'($random(seed));
    pend = sel && !rd;
    pd0 = 18'($random(seed));
    pd1 = 18'($random(seed));
    pl0 = all_lanes ? 2'h0 : 2'($random(seed));
    pl1 = all_lanes ? 2'h0 : 2'($random(seed));
    if (pend) begin
      mem[{a, b0}]  = merge(mem[{a, b0}], pd0, pl0);
      mem[{a, ~b0}] = merge(mem[{a, ~b0}], pd1, pl1);
    end
  endtask : op

  task automatic traffic(int n);
    repeat (n) op(($random(seed) & 3) != 0, 1'($random(seed)), 9'($random(seed)),
                  1'($random(seed)));
  endtask : traffic

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #400us;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) op(1'b0, 1'b1, 9'h1AA, 1'b1);
    mon_en = 1'b1;
    all_lanes = 1'b1;
    for (int a = 0; a < 512; a++) op(1'b1, 1'b0, 9'(a), 1'b0);
    all_lanes = 1'b0;
    $display("test fill done");
    for (int p = 1; p >= 0; p--) begin
      pll_disable_n <= 1'(p);
      repeat (4) op(1'b0, 1'b0, 9'h0, 1'b0);
      op(1'b1, 1'b0, 9'h155, 1'b1);
      op(1'b1, 1'b1, 9'h155, 1'b0);
      op(1'b1, 1'b1, 9'h155, 1'b1);
      traffic(300);
      repeat (4) op(1'b0, 1'b0, 9'h0, 1'b0);
      $display("test random latency mode %0d done", p);
    end
    mon_en = 1'b0;
    single = 1'b1;
    repeat (12) op(1'b0, 1'b0, 9'h0, 1'b0);
    mon_en = 1'b1;
    traffic(100);
    repeat (4) op(1'b0, 1'b0, 9'h0, 1'b0);
    $display("test single clock done");
    print_verdict();
  end
endmodule : tb

bind ddr_burst2_sram_port sram_port_chk #(.DATA_WIDTH(DATA_WIDTH)) i_chk (
  .clk_sys, .reset_n, .in_clk_p, .in_clk_n, .out_clk_p, .out_clk_n, .load_strobe_n,
  .access_direction, .dq_out, .dq_oe, .echo_clock_p, .echo_clock_n);

`default_nettype wire
